// [inc/shared_data_consts.vh]
// Purpose: Constants for the shared variable access channel
// Assumes: APB byte addresses, 16-bit process image words
// Notes: Included by bare name from the design file
`ifndef SHARED_DATA_CONSTS_VH
`define SHARED_DATA_CONSTS_VH
// ==========================================
// APB register offsets
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_SEL 8'h08
`define REG_NAME_LO 8'h0c
`define REG_NAME_HI 8'h10
`define REG_ATTR 8'h14
`define REG_VIDX 8'h18
`define REG_VDAT 8'h1c
// ==========================================
// Field positions and reset values
`define CTRL_FLOAT 0
`define CTRL_EN 1
`define CTRL_SLOT_LO 2
`define CTRL_SLOT_HI 3
`define CTRL_RST 4'h2
`define ATTR_STR 0
`define ATTR_WP 1
`define ATTR_LEN_LO 4
`define ATTR_LEN_HI 7
`define ATTR_RST 8'h20
// ==========================================
// Command and result codes
`define CMD_NOP 16'h0000
`define CMD_READ 16'h0001
`define CMD_WRITE 16'h0002
`define RES_NULL 16'h0000
`define RES_OK 16'h0001
`define RES_BAD_NAME 16'h0002
`define RES_BAD_CMD 16'h0003
`define RES_PROTECT 16'h0004
// ==========================================
// Image geometry
`define VAL_WORDS 10
`define IMG_WORDS 28
`endif

// [hdl/shared_data_plc_access.v]
// Purpose: Shared variable access channel of the cyclic fieldbus image
// Assumes: Image ports and APB share pclk; controller side is plain logic
// Notes: One access per change of the command word; read field is a snapshot
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "shared_data_consts.vh"

module shared_data_plc_access #(
	parameter NV = 4,
	parameter VI = 2
) (
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire oimg_we,
	input wire [4:0] oimg_addr,
	input wire [15:0] oimg_data,
	input wire [4:0] iimg_addr,
	input wire [15:0] slot_word,
	output reg [15:0] iimg_data
);

// ==========================================
// State
// Control word and the copy of the controller's output image
reg [3:0] ctrl;
reg [15:0] oimg [0:`IMG_WORDS-1];
// Variable catalogue: name, attributes and up to ten value words each
reg [47:0] var_name [0:NV-1];
reg [7:0] var_attr [0:NV-1];
reg [159:0] var_val [0:NV-1];
// Access results as the controller sees them
reg [159:0] rd_field;
reg [15:0] result;
// Command history for change detection and the status register
reg [15:0] prev_cmd;
reg [15:0] last_cmd;
reg [7:0] acc_count;
// Catalogue pointers used by software
reg [VI-1:0] sel;
reg [3:0] vidx;

// ==========================================
// Image layout decode
wire fmode = ctrl[`CTRL_FLOAT];
wire [4:0] ns = {3'b000, ctrl[`CTRL_SLOT_HI:`CTRL_SLOT_LO]} + 5'd1;
// Command word position in the output image
wire [4:0] cmd_idx = fmode ? (ns + ns + ns + 5'd1) : (ns + ns);
wire [4:0] nm_idx = cmd_idx + 5'd2;
wire [4:0] wv_idx = cmd_idx + 5'd5;
// Status and read field positions in the input image
wire [4:0] st_idx = fmode ? {ns[2:0], 2'b00} : (ns + ns + 5'd1);
wire [4:0] rd_idx = st_idx + 5'd1;
wire [15:0] cmd = oimg[cmd_idx];
wire [47:0] name = {oimg[nm_idx], oimg[nm_idx + 5'd1], oimg[nm_idx + 5'd2]};

// Write value gathered from the output image, word 0 in the low bits
// Words past the image end read as zero rather than wrapping round
reg [159:0] wv;
reg [4:0] k;
integer j;
always @* begin
	k = 5'd0;
	wv = 160'h0;
	for (j = 0; j < `VAL_WORDS; j = j + 1) begin
		k = wv_idx + j[4:0];
		wv[j*16 +: 16] = (k < `IMG_WORDS) ? oimg[k] : 16'h0000;
	end
end

// ==========================================
// Variable lookup
wire [NV-1:0] hit;
genvar g;
generate
	for (g = 0; g < NV; g = g + 1) begin : match
		assign hit[g] = (var_name[g] == name);
	end
endgenerate

// All names are compared at once so the decision takes a single cycle
// Lowest matching entry wins if names repeat
reg found;
reg [VI-1:0] idx;
integer m;
always @* begin
	found = 1'b0;
	idx = {VI{1'b0}};
	for (m = NV - 1; m >= 0; m = m - 1) begin
		if (hit[m]) begin
			found = 1'b1;
			idx = m[VI-1:0];
		end
	end
end

wire [7:0] attr = var_attr[idx];
wire [3:0] vlen = attr[`ATTR_LEN_HI:`ATTR_LEN_LO];

// Keep only the words the variable really owns
// Words beyond the variable's length reach the read field as zero, never as stale data
reg [159:0] lmask;
integer n;
always @* begin
	lmask = 160'h0;
	for (n = 0; n < `VAL_WORDS; n = n + 1) begin
		if (n < vlen)
			lmask[n*16 +: 16] = 16'hffff;
	end
end

// Printable character or padding
function prt;
	input [7:0] b;
	begin
		prt = (b == 8'h00) || ((b >= 8'h20) && (b <= 8'h7e));
	end
endfunction

// Float payload into a string, or string payload into a float
// Limitation: only the first value word of a string is checked, to keep the compare small
wire type_bad = attr[`ATTR_STR] ? !(prt(wv[15:8]) && prt(wv[7:0])) : (wv[159:32] != 128'h0);

// ==========================================
// APB slave: zero wait states, read data captured in the setup phase, write data in the access phase
// No wait states are needed because every register answers from flip-flops
wire setup = psel && !penable;
wire wr_acc = psel && penable && pwrite;
wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `REG_VDAT);
assign pready = 1'b1;
assign pslverr = psel && penable && !mapped;

// Read data mux, registered so it stands through the access phase
reg [31:0] rmux;
always @* begin
	case (paddr)
	`REG_CTRL: rmux = {28'h0, ctrl};
	`REG_STAT: rmux = {acc_count, last_cmd[7:0], result};
	`REG_SEL: rmux = {{(32-VI){1'b0}}, sel};
	`REG_NAME_LO: rmux = var_name[sel][31:0];
	`REG_NAME_HI: rmux = {16'h0, var_name[sel][47:32]};
	`REG_ATTR: rmux = {24'h0, var_attr[sel]};
	`REG_VIDX: rmux = {28'h0, vidx};
	`REG_VDAT: rmux = {16'h0, var_val[sel][vidx*16 +: 16]};
	default: rmux = 32'h0;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		prdata <= 32'h0;
	else if (ce && setup)
		prdata <= rmux;
end

// ==========================================
// Output image capture from the fieldbus side
integer q;
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		for (q = 0; q < `IMG_WORDS; q = q + 1)
			oimg[q] <= 16'h0000;
	end else if (ce && oimg_we && (oimg_addr < `IMG_WORDS)) begin
		oimg[oimg_addr] <= oimg_data;
	end
end

// ==========================================
// Control registers written by software
// Out of range word indexes are ignored so the pointer never leaves the value
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ctrl <= `CTRL_RST;
		sel <= {VI{1'b0}};
		vidx <= 4'h0;
	end else if (ce && wr_acc) begin
		if (paddr == `REG_CTRL)
			ctrl <= pwdata[3:0];
		if (paddr == `REG_SEL)
			sel <= pwdata[VI-1:0];
		if ((paddr == `REG_VIDX) && (pwdata[3:0] < `VAL_WORDS))
			vidx <= pwdata[3:0];
	end
end

// ==========================================
// Access engine and variable store
// Software catalogue writes land first; an access in the same cycle
// overrides them so the controller never loses its write.
// A disabled channel never fires, so a half-loaded image cannot start an access
wire en = ctrl[`CTRL_EN];
wire fire = en && (cmd != prev_cmd);
integer r;
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		for (r = 0; r < NV; r = r + 1) begin
			var_name[r] <= 48'h0;
			var_attr[r] <= `ATTR_RST;
			var_val[r] <= 160'h0;
		end
		rd_field <= 160'h0;
		result <= `RES_NULL;
		prev_cmd <= `CMD_NOP;
		last_cmd <= `CMD_NOP;
		acc_count <= 8'h00;
	end else if (ce) begin
		if (wr_acc) begin
			if (paddr == `REG_NAME_LO)
				var_name[sel][31:0] <= pwdata;
			if (paddr == `REG_NAME_HI)
				var_name[sel][47:32] <= pwdata[15:0];
			if (paddr == `REG_ATTR)
				var_attr[sel] <= pwdata[7:0];
			if (paddr == `REG_VDAT)
				var_val[sel][vidx*16 +: 16] <= pwdata[15:0];
		end
		// Track the command even while disabled so enabling does not fire
		prev_cmd <= cmd;
		if (fire) begin
			last_cmd <= cmd;
			acc_count <= acc_count + 8'h01;
			// Non-read commands leave no read value behind
			rd_field <= 160'h0;
			case (cmd)
			`CMD_NOP: begin
				result <= `RES_NULL;
			end
			`CMD_READ: begin
				if (!found)
					result <= `RES_BAD_NAME;
				else begin
					rd_field <= var_val[idx] & lmask;
					result <= `RES_OK;
				end
			end
			`CMD_WRITE: begin
				if (!found)
					result <= `RES_BAD_NAME;
				else if (attr[`ATTR_WP])
					result <= `RES_PROTECT;
				else if (type_bad)
					result <= `RES_BAD_CMD;
				else begin
					var_val[idx] <= wv & lmask;
					result <= `RES_OK;
				end
			end
			default: begin
				result <= `RES_BAD_CMD;
			end
			endcase
		end
	end
end

// ==========================================
// Input image read port, one cycle latency
// Priority: status word, then read field, then null word, then slot data
// The registered output gives the fieldbus side a clean flip-flop to sample
wire [4:0] roff = iimg_addr - rd_idx;
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		iimg_data <= 16'h0000;
	else if (ce) begin
		if (iimg_addr == st_idx)
			iimg_data <= result;
		else if ((iimg_addr >= rd_idx) && (roff < `VAL_WORDS))
			iimg_data <= rd_field[roff*16 +: 16];
		else if (!fmode && (iimg_addr == st_idx - 5'd1))
			iimg_data <= 16'h0000;
		else
			iimg_data <= slot_word;
	end
end

endmodule // shared_data_plc_access

// [verification/plc_model.sv]
// Purpose: Controller model on the image side
// Assumes: Called by the bench right after an edge
// Notes: Data lines are scrambled when idle
`timescale 1ns/1ns
// =====
// Model
module plc_model (
	input wire pclk,
	output reg oimg_we = 1'b0,
	output reg [4:0] oimg_addr = 5'h0,
	output reg [15:0] oimg_data = 16'h0,
	output reg [4:0] iimg_addr = 5'h0,
	input wire [15:0] iimg_data
);
	// One word per edge, strobe held between words
	task put(input [4:0] a, input [15:0] d);
		begin
			oimg_we <= 1'b1;
			oimg_addr <= a;
			oimg_data <= d;
			@(posedge pclk);
		end
	endtask
	// Released lines must not look like valid data
	task idle;
		begin
			oimg_we <= 1'b0;
			oimg_data <= ~oimg_data;
			@(posedge pclk);
		end
	endtask
	// Registered word, one edge after its address
	task get(input [4:0] a, output [15:0] d);
		begin
			iimg_addr <= a;
			@(posedge pclk);
			@(posedge pclk);
			d = iimg_data;
		end
	endtask
endmodule // plc_model

// [verification/shared_data_plc_access_assertions.sv]
// Purpose: Port checks of the access channel
// Assumes: One clock domain
// Notes: Bound below
`timescale 1ns/1ns
`include "shared_data_consts.vh"
// =====
// Checker
module sdpa_chk #(
	parameter NV = 4,
	parameter VI = 2
) (
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire oimg_we,
	input wire [4:0] iimg_addr,
	input wire [15:0] slot_word,
	input wire [15:0] iimg_data
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answer, error only on unmapped access
	AST_READY: assert property (pready) else $error("pready low");
	AST_ERR: assert property (psel && penable && (paddr > `REG_VDAT || paddr[1:0] != 2'b00) |-> pslverr)
		else $error("no error on unmapped");
	AST_NOERR: assert property (psel && penable && paddr <= `REG_VDAT && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("error on mapped");
	AST_IDLE: assert property (!(psel && penable) |-> !pslverr) else $error("error outside access");
	AST_HOLD: assert property (!(psel && !penable && ce) |=> $stable(prdata)) else $error("prdata moved");
	// Frozen state while the enable is low
	AST_FREEZE: assert property (!ce |=> $stable(iimg_data)) else $error("image moved");
	// Quiet inputs leave the read field alone
	AST_SNAP: assert property ((presetn && ce && !psel && !oimg_we && $stable(iimg_addr)
		&& $stable(slot_word)) [*5] |-> $stable(iimg_data)) else $error("field refreshed");
	AST_CODE: assert property (psel && penable && !pwrite
		&& paddr == `REG_STAT |-> prdata[15:0] <= 16'h0004) else $error("bad result code");
	C_ERR: cover property (psel && penable && pslverr);
	C_FRZ: cover property (!ce);
	C_WR: cover property (oimg_we);
endmodule // sdpa_chk
bind shared_data_plc_access sdpa_chk #(.NV(NV), .VI(VI)) chk_u (.*);

// [verification/tb.sv]
// Purpose: Self-checking bench of the access channel
// Assumes: Model drives the image ports
// Notes: Random values from an LFSR
`timescale 1ns/1ns
`include "shared_data_consts.vh"
// =====
// Bench
module tb;
	reg pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg [7:0] paddr = 8'h0;
	reg [31:0] pwdata = 32'h0, rnd = 32'hb21ff36c, rd, c0;
	reg [15:0] slot_word = 16'h0, w0, w1, g;
	reg [4:0] ci, si;
	reg [3:0] cf;
	wire [31:0] prdata;
	wire pready, pslverr, oimg_we;
	wire [4:0] oimg_addr, iimg_addr;
	wire [15:0] oimg_data, iimg_data;
	integer miscompares = 0, comparisons = 0, i, n;
	shared_data_plc_access dut_u (.*);
	plc_model plc_u (.*);
	always #10 pclk = ~pclk;
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Word positions of a layout
	function [4:0] cmd_at(input [3:0] c);
		cmd_at = c[0] ? 5'd3 * (c[3:2] + 5'd1) + 5'd1 : 5'd2 * (c[3:2] + 5'd1);
	endfunction
	function [4:0] stat_at(input [3:0] c);
		stat_at = c[0] ? 5'd4 * (c[3:2] + 5'd1) : 5'd2 * (c[3:2] + 5'd1) + 5'd1;
	endfunction
	task close_out;
		begin
			if (miscompares == 0 && comparisons > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				miscompares = miscompares + 1;
				$display("[FAIL] %0s exp %h got %h", nm, e, s);
			end
		end
	endtask
	// One transfer, pready waited for under a bound
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			@(posedge pclk);
			while (pready !== 1'b1 && n < 20) begin
				n = n + 1;
				@(posedge pclk);
			end
			rd = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
			if (n == 20) begin
				miscompares = miscompares + 1;
				close_out;
			end
		end
	endtask
	// Name and value under no-op, then the command
	task acc(input [15:0] c, input [47:0] nm, input [15:0] v2, input [15:0] es);
		begin
			slot_word <= rnd[15:0];
			plc_u.put(ci, `CMD_NOP);
			plc_u.put(ci + 5'd2, nm[47:32]);
			plc_u.put(ci + 5'd3, nm[31:16]);
			plc_u.put(ci + 5'd4, nm[15:0]);
			plc_u.put(ci + 5'd5, w0);
			plc_u.put(ci + 5'd6, w1);
			plc_u.put(ci + 5'd7, v2);
			plc_u.put(ci, c);
			plc_u.idle;
			plc_u.get(si, g);
			chk("status", es, g);
		end
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares = miscompares + 1;
		close_out;
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h20, 32'h0);
		apb(1'b1, `REG_SEL, 32'h1);
		apb(1'b1, `REG_NAME_HI, 32'h7374);
		apb(1'b1, `REG_NAME_LO, 32'h30313032);
		apb(1'b1, `REG_ATTR, 32'h23);
		apb(1'b1, `REG_SEL, 32'h0);
		apb(1'b1, `REG_NAME_HI, 32'h7774);
		apb(1'b1, `REG_NAME_LO, 32'h30313031);
		// A read in both image formats, with one slot and with four slots
		for (i = 0; i < 4; i = i + 1) begin
			cf = {i[1], i[1], 1'b1, i[0]};
			ci = cmd_at(cf);
			si = stat_at(cf);
			apb(1'b1, `REG_CTRL, {28'h0, cf});
			rnd = lfsr(rnd);
			w0 = rnd[15:0];
			w1 = rnd[31:16];
			apb(1'b1, `REG_VIDX, 32'h0);
			apb(1'b1, `REG_VDAT, {16'h0, w0});
			apb(1'b1, `REG_VIDX, 32'h2);
			apb(1'b1, `REG_VDAT, 32'h0000a5a5);
			apb(1'b1, `REG_VIDX, 32'h1);
			apb(1'b1, `REG_VDAT, {16'h0, w1});
			acc(`CMD_READ, 48'h777430313031, 16'h0, `RES_OK);
			plc_u.get(si + 5'd1, g);
			chk("field0", w0, g);
			plc_u.get(si + 5'd3, g);
			chk("field2", 16'h0, g);
			apb(1'b1, `REG_VDAT, {16'h0, ~w1});
			plc_u.get(si + 5'd2, g);
			chk("snapshot", w1, g);
			plc_u.put(ci, `CMD_NOP);
			plc_u.idle;
			plc_u.get(si + 5'd1, g);
			chk("cleared", 16'h0, g);
			plc_u.get(5'd0, g);
			chk("slot", {16'h0, rnd[15:0]}, g);
			plc_u.get(si - 5'd1, g);
			chk("null", cf[0] ? {16'h0, rnd[15:0]} : 32'h0, g);
		end
		apb(1'b0, `REG_STAT, 32'h0);
		c0 = rd;
		acc(`CMD_READ, 48'h777430313031, 16'h0, `RES_OK);
		ce <= 1'b0;
		repeat (3) @(posedge pclk);
		ce <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(1'b0, `REG_STAT, 32'h0);
		chk("count", {24'h0, c0[31:24] + 8'h1}, rd[31:24]);
		w0 = 16'h4142;
		acc(`CMD_WRITE, 48'h777430313031, 16'h0, `RES_OK);
		apb(1'b1, `REG_VIDX, 32'h0);
		apb(1'b0, `REG_VDAT, 32'h0);
		chk("stored", w0, rd[15:0]);
		acc(`CMD_WRITE, 48'h777430313031, 16'h1, `RES_BAD_CMD);
		acc(`CMD_WRITE, 48'h737430313032, 16'h0, `RES_PROTECT);
		acc(`CMD_READ, 48'h7a7a7a7a7a7a, 16'h0, `RES_BAD_NAME);
		acc(16'h0003, 48'h777430313031, 16'h0, `RES_BAD_CMD);
		// String variable: unprintable data refused, text stored and read back
		apb(1'b1, `REG_SEL, 32'h2);
		apb(1'b1, `REG_NAME_HI, 32'h7374);
		apb(1'b1, `REG_NAME_LO, 32'h30313033);
		apb(1'b1, `REG_ATTR, 32'h21);
		w0 = 16'h0102;
		acc(`CMD_WRITE, 48'h737430313033, 16'h0, `RES_BAD_CMD);
		w0 = 16'h4142;
		acc(`CMD_WRITE, 48'h737430313033, 16'h0, `RES_OK);
		acc(`CMD_READ, 48'h737430313033, 16'h0, `RES_OK);
		plc_u.get(si + 5'd1, g);
		chk("strread", 16'h4142, g);
		close_out;
	end
endmodule // tb
